// ===== pchk_pkg.sv
// package for the streaming pattern checker: widths, field layouts, descriptor types
// assumes one clock domain; parameters are fixed at the values chosen here
package pchk_pkg;
  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  localparam int BITS_PER_SYMBOL = 8;
  localparam int SYMBOLS_PER_BEAT = 4;
  localparam int DATA_W = BITS_PER_SYMBOL * SYMBOLS_PER_BEAT;
  localparam int NUM_CHANNELS = 4;
  localparam int CHAN_W = 2;
  localparam int ERR_W = 2;
  localparam int EMPTY_W = 2;
  localparam bit PACKETS = 1'b1;
  localparam int POS_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam int THR_W = 9;
  localparam logic [THR_W-1:0] THROTTLE_RST = 9'h100;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [7:0] DATA_MASK_RST = 8'h00;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam logic [15:0] ID_VALUE = 16'h00A5; // arbitrary identity value
  localparam int ST_ID_LSB = 0;
  localparam int ST_CHAN_LSB = 16;
  localparam int ST_SYM_LSB = 24;
  localparam int ST_PKT_BIT = 31;

  // ---------------------------------------------------------------
  // exception kinds and descriptor
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EXC_DATA = 2'h0,
    EXC_NO_SOP = 2'h1,
    EXC_NO_EOP = 2'h2,
    EXC_SIGNALED = 2'h3
  } exc_kind_t;

  typedef struct packed {
    exc_kind_t kind;
    logic [7:0] channel;
  } exc_desc_t;

  localparam int DESC_W = 10;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic [CHAN_W-1:0] channel;
    logic [ERR_W-1:0] error;
    logic sop;
    logic eop;
    logic [EMPTY_W-1:0] empty;
  } st_beat_t;
endpackage

// ===== pchk_exc_fifo.sv
// exception queue: flip-flop storage, pushes dropped while full
// assumes the caller pops only when empty_o is low
`timescale 1ns/1ps
module pchk_exc_fifo (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic push,
  input wire pchk_pkg::exc_desc_t push_desc,
  input wire logic pop,
  output pchk_pkg::exc_desc_t head,
  output logic empty_o,
  output logic full_o,
  output logic [pchk_pkg::FIFO_AW:0] fill
);
  import pchk_pkg::*;

  exc_desc_t mem_r [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_r;
  logic [FIFO_AW-1:0] rp_r;
  logic [FIFO_AW:0] cnt_r;
  wire do_push = push && !full_o;
  wire do_pop = pop && !empty_o;

  assign empty_o = (cnt_r == '0);
  assign full_o = (cnt_r == (FIFO_AW+1)'(FIFO_DEPTH));
  assign fill = cnt_r;
  assign head = mem_r[rp_r];

  always_ff @(posedge ref_clk) begin
    if (clk_en && do_push) begin
      mem_r[wp_r] <= push_desc;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop) rp_r <= rp_r + 1'b1;
      if (do_push && !do_pop) cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ===== pchk_top.sv
// streaming pattern checker: per-channel position tracking, throttled ready, exception queue
// assumes the source holds a beat until ready; control bits are plain ports sampled on ref_clk
`timescale 1ns/1ps
module pchk_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pchk_pkg::st_beat_t in_beat,
  output logic in_ready,
  input wire logic enable,
  input wire logic soft_reset,
  input wire logic [pchk_pkg::THR_W-1:0] throttle,
  input wire logic [7:0] data_mask,
  output logic [31:0] status_word,
  input wire logic exc_read,
  output logic [31:0] exc_word,
  output logic exc_valid,
  output logic [pchk_pkg::FIFO_AW:0] exc_fill
);
  import pchk_pkg::*;

  // ---------------------------------------------------------------
  // parameter sanity
  // ---------------------------------------------------------------
  // elaboration-time range limits; a bad package edit stops the build here
  if (SYMBOLS_PER_BEAT < 1 || SYMBOLS_PER_BEAT > 32) begin : g_bad_sym
    $error("symbols per beat out of range");
  end
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 256) begin : g_bad_chan
    $error("channel count out of range");
  end
  if (ERR_W < 0 || ERR_W > 31) begin : g_bad_err
    $error("error width out of range");
  end
  if (DATA_W != BITS_PER_SYMBOL * SYMBOLS_PER_BEAT) begin : g_bad_w
    $error("data width is not a whole number of symbols");
  end
  // the hand-set widths must still cover the counts they index
  if ((1 << CHAN_W) < NUM_CHANNELS) begin : g_bad_chan_w
    $error("channel field too narrow");
  end
  if ((1 << EMPTY_W) < SYMBOLS_PER_BEAT) begin : g_bad_empty_w
    $error("empty field too narrow");
  end
  if (FIFO_DEPTH != (1 << FIFO_AW)) begin : g_bad_depth
    $error("queue depth and pointer width disagree");
  end
  if (DESC_W != $bits(exc_desc_t)) begin : g_bad_desc
    $error("descriptor width disagrees with its type");
  end

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  wire [7:0] chan_field = 8'(NUM_CHANNELS - 1);
  wire [6:0] sym_field = 7'(SYMBOLS_PER_BEAT);
  assign status_word = {PACKETS, sym_field, chan_field, ID_VALUE};

  // ---------------------------------------------------------------
  // throttle: lfsr compared with threshold
  // ---------------------------------------------------------------
  logic [15:0] lfsr_r;
  wire [15:0] lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  // 256 or more always accepts; 0 never accepts
  wire thr_ok = ({1'b0, lfsr_r[7:0]} < throttle);
  // a frozen block must not signal acceptance, or the source would lose the beat
  wire active = enable && !soft_reset && clk_en;
  assign in_ready = active && thr_ok;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_r <= LFSR_SEED;
    end else if (clk_en) begin
      lfsr_r <= lfsr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  logic [POS_W-1:0] pos_r [NUM_CHANNELS];
  logic in_pkt_r [NUM_CHANNELS];
  wire take = in_beat.valid && in_ready;
  wire [CHAN_W-1:0] ch = in_beat.channel;
  wire [POS_W-1:0] cur_pos = pos_r[ch];
  wire cur_in_pkt = in_pkt_r[ch];
  // without packet support sop/eop are ignored entirely
  wire sop = PACKETS && in_beat.sop;
  wire eop = PACKETS && in_beat.eop;
  // a fresh sop restarts the position count
  wire [POS_W-1:0] base_pos = sop ? '0 : cur_pos;
  wire [EMPTY_W:0] n_valid = eop ? (EMPTY_W+1)'(SYMBOLS_PER_BEAT) - {1'b0, in_beat.empty}
                                 : (EMPTY_W+1)'(SYMBOLS_PER_BEAT);

  // ---------------------------------------------------------------
  // symbol compare
  // ---------------------------------------------------------------
  wire [SYMBOLS_PER_BEAT-1:0] sym_bad;
  genvar gi;
  for (gi = 0; gi < SYMBOLS_PER_BEAT; gi++) begin : g_sym
    wire [POS_W-1:0] p = base_pos + POS_W'(gi);
    // first symbol sits in the most significant lane
    wire [BITS_PER_SYMBOL-1:0] got =
      in_beat.data[DATA_W-1-gi*BITS_PER_SYMBOL -: BITS_PER_SYMBOL];
    wire [BITS_PER_SYMBOL-1:0] exp = p[BITS_PER_SYMBOL-1:0] ^ data_mask;
    assign sym_bad[gi] = ((EMPTY_W+1)'(gi) < n_valid) && (got != exp);
  end

  wire ev_data = |sym_bad;
  wire ev_nosop = PACKETS && !sop && !cur_in_pkt;
  wire ev_noeop = PACKETS && sop && cur_in_pkt;
  wire ev_sig = (ERR_W > 0) && (in_beat.error != '0);

  // one descriptor per beat; priority favours the most telling fault
  exc_kind_t ev_kind;
  assign ev_kind = ev_sig ? EXC_SIGNALED :
                   ev_noeop ? EXC_NO_EOP :
                   ev_nosop ? EXC_NO_SOP : EXC_DATA;
  wire ev_any = take && (ev_data || ev_nosop || ev_noeop || ev_sig);

  exc_desc_t ev_desc;
  assign ev_desc = '{kind: ev_kind, channel: 8'(ch)};

  // ---------------------------------------------------------------
  // repeat suppression
  // ---------------------------------------------------------------
  logic last_vld_r;
  exc_desc_t last_r;
  // a clean beat ends a run, so the next exception counts as new
  wire repeat_ev = last_vld_r && (last_r == ev_desc);
  wire push = ev_any && !repeat_ev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_vld_r <= 1'b0;
      last_r <= '0;
    end else if (clk_en) begin
      if (soft_reset) begin
        last_vld_r <= 1'b0;
      end else if (take) begin
        last_vld_r <= ev_any;
        last_r <= ev_desc;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel state update
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        pos_r[i] <= '0;
        in_pkt_r[i] <= 1'b0;
      end
    end else if (clk_en) begin
      if (soft_reset) begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
          pos_r[i] <= '0;
          in_pkt_r[i] <= 1'b0;
        end
      end else if (take) begin
        pos_r[ch] <= eop ? '0 : base_pos + POS_W'(SYMBOLS_PER_BEAT);
        in_pkt_r[ch] <= !eop;
      end
    end
  end

  // ---------------------------------------------------------------
  // exception queue and read port
  // ---------------------------------------------------------------
  exc_desc_t head;
  logic q_empty;
  logic q_full;
  // full queue silently drops; the fifo refuses pushes while full
  wire pop = exc_read && !q_empty;

  pchk_exc_fifo u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .push(push),
    .push_desc(ev_desc),
    .pop(pop),
    .head(head),
    .empty_o(q_empty),
    .full_o(q_full),
    .fill(exc_fill)
  );

  assign exc_valid = !q_empty;
  // bit 31 flags a valid entry; kind in 9:8, channel in 7:0
  // an empty queue reads as zero rather than a stale or unwritten slot
  assign exc_word = q_empty ? 32'h0 : {1'b1, 21'h0, head.kind, head.channel};
endmodule

// ===== pchk_top_sva.sv
// checker for the pattern checker: ready gating, status constant, queue bookkeeping
// assumes it is bound to pchk_top and sees only its ports
`timescale 1ns/1ps
module pchk_top_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pchk_pkg::st_beat_t in_beat,
  input wire logic in_ready,
  input wire logic enable,
  input wire logic soft_reset,
  input wire logic [pchk_pkg::THR_W-1:0] throttle,
  input wire logic [7:0] data_mask,
  input wire logic [31:0] status_word,
  input wire logic exc_read,
  input wire logic [31:0] exc_word,
  input wire logic exc_valid,
  input wire logic [pchk_pkg::FIFO_AW:0] exc_fill
);
  import pchk_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ready_disabled: assert property (!enable || soft_reset |-> !in_ready)
    else $error("ready high while acceptance is off");
  a_ready_zero_thr: assert property (throttle == 9'h000 |-> !in_ready)
    else $error("ready high with zero throttle");
  a_ready_full_thr: assert property (clk_en && enable && !soft_reset
    && throttle >= 9'h100 |-> in_ready)
    else $error("ready low with full throttle");
  a_ready_frozen: assert property (!clk_en |-> !in_ready)
    else $error("ready high while the clock enable is low");
  a_freeze_fill: assert property (!clk_en |=> $stable(exc_fill))
    else $error("queue fill moved while the clock enable is low");
  a_empty_word: assert property (!exc_valid |-> exc_word == 32'h0)
    else $error("exception word not zero on an empty queue");
  a_status_const: assert property (status_word == {PACKETS, 7'h04, 8'h03, ID_VALUE})
    else $error("status word wrong");
  a_valid_fill: assert property (exc_valid == (exc_fill != 0) && exc_word[31] == exc_valid)
    else $error("exception valid disagrees with fill");
  a_fill_limit: assert property (exc_fill <= 6'h20)
    else $error("fill beyond queue depth");
  a_full_drop: assert property (exc_fill == 6'h20 && !exc_read |=> exc_fill == 6'h20)
    else $error("full queue changed without a read");
  a_pop_shrinks: assert property (clk_en && exc_read && exc_valid |=> exc_fill <= $past(exc_fill))
    else $error("read did not pop");
  a_push_one: assert property (exc_fill <= $past(exc_fill) + 1)
    else $error("more than one push per cycle");
endmodule

bind pchk_top pchk_top_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .in_beat(in_beat), .in_ready(in_ready), .enable(enable), .soft_reset(soft_reset),
  .throttle(throttle), .data_mask(data_mask), .status_word(status_word),
  .exc_read(exc_read), .exc_word(exc_word), .exc_valid(exc_valid), .exc_fill(exc_fill));

// ===== pchk_src_model.sv
// stream source standing in for the upstream sender that feeds the component under test
// assumes send and idle are called just after a rising edge
`timescale 1ns/1ps
module pchk_src_model (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic in_ready,
  output pchk_pkg::st_beat_t beat
);
  import pchk_pkg::*;
  initial beat = '0;
  // a beat stands whole until the edge that takes it
  task automatic send(input st_beat_t b, output bit ok);
    int i;
    beat <= b;
    for (i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if (in_ready && clk_en) break;
    end
    ok = (i < 400);
    @(posedge ref_clk);
  endtask
  // each idle call inverts the data once and drops valid so a stale beat never passes for a fresh one
  task automatic idle();
    beat <= '{valid: 1'b0, data: ~beat.data, default: '0};
  endtask
endmodule

// ===== pchk_top_tb_top.sv
// self-checking bench for the pattern checker with a queue-based reference model
// assumes the package configuration: 4 channels, 4 symbols per beat, packets on
`timescale 1ns/1ps
module pchk_top_tb_top;
  import pchk_pkg::*;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, enable = 0, soft_reset = 0, exc_read = 0;
  logic [THR_W-1:0] throttle = 9'h100;
  logic [7:0] data_mask = 8'h00;
  logic [31:0] status_word, exc_word;
  logic in_ready, exc_valid;
  logic [FIFO_AW:0] exc_fill;
  st_beat_t in_beat;
  int err_count = 0, total_checks = 0, pos[4], inp[4], last = -1, i;
  int q[$];
  bit ok;
  always #5 ref_clk = ~ref_clk;
  pchk_src_model u_src (.ref_clk(ref_clk), .clk_en(clk_en), .in_ready(in_ready), .beat(in_beat));
  pchk_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .in_beat(in_beat),
    .in_ready(in_ready), .enable(enable), .soft_reset(soft_reset), .throttle(throttle),
    .data_mask(data_mask), .status_word(status_word), .exc_read(exc_read),
    .exc_word(exc_word), .exc_valid(exc_valid), .exc_fill(exc_fill));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reference: position per channel, packet state, run memory, bounded queue
  task automatic tx(int c, bit s, bit e, int er, int em, logic [31:0] flip);
    logic [31:0] d;
    int k;
    if (s) pos[c] = 0;
    for (k = 0; k < 4; k++) d[31-8*k -: 8] = 8'(pos[c] + k) ^ data_mask;
    u_src.send('{1'b1, d ^ flip, 2'(c), 2'(er), s, e, 2'(em)}, ok);
    if (!ok) begin
      err_count++;
      conclude();
    end
    k = er ? 3 : (s && inp[c]) ? 2 : (!s && !inp[c]) ? 1 : (flip >> 8 * em) ? 0 : -1;
    if (k < 0) last = -1;
    else if (k * 4 + c != last) begin
      last = k * 4 + c;
      if (q.size() < 32) q.push_back(k * 256 + c);
    end
    pos[c] += 4;
    inp[c] = !e;
    if (e) pos[c] = 0;
  endtask
  task automatic drain();
    u_src.idle();
    repeat (2) @(posedge ref_clk);
    // a read held while the clock enable is low must leave the queue alone
    exc_read <= 1;
    clk_en <= 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("fill", exc_fill, q.size());
    chk("frozen ready", in_ready, 0);
    @(posedge ref_clk);
    clk_en <= 1;
    while (q.size()) begin
      @(negedge ref_clk);
      chk("desc", exc_word, 32'h80000000 | q.pop_front());
      @(posedge ref_clk);
    end
    // one more read on an empty queue must be ignored
    @(posedge ref_clk);
    exc_read <= 0;
    @(negedge ref_clk);
    chk("empty", {exc_valid, exc_fill}, 0);
    chk("empty word", exc_word, 0);
    @(posedge ref_clk);
  endtask
  initial begin
    i = $urandom(37357);
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    for (i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      enable <= i > 0;
      soft_reset <= i == 1;
      throttle <= (i == 2) ? 9'h000 : 9'h100;
      repeat (16) begin
        @(negedge ref_clk);
        chk("ready", in_ready, 0);
      end
    end
    @(posedge ref_clk);
    soft_reset <= 0;
    throttle <= 9'h100;
    data_mask <= 8'($urandom);
    chk("status", status_word, {PACKETS, 7'h04, 8'h03, ID_VALUE});
    $display("test gating done");
    @(posedge ref_clk);
    tx(0, 1, 0, 0, 0, 0);
    tx(1, 1, 0, 0, 0, 0);
    tx(0, 0, 0, 0, 0, 0);
    tx(1, 0, 1, 0, 1, 32'hFF);
    tx(0, 0, 1, 0, 0, 0);
    tx(1, 1, 0, 0, 0, 32'h00010000);
    tx(1, 0, 0, 0, 0, 32'h00010000);
    tx(0, 1, 0, 0, 0, 0);
    tx(1, 0, 1, 0, 0, 32'h01000000);
    tx(2, 0, 0, 0, 0, 0);
    tx(2, 0, 0, 0, 0, 0);
    tx(3, 1, 1, 2, 0, 0);
    tx(0, 1, 0, 0, 0, 0);
    tx(0, 0, 1, 0, 0, 0);
    drain();
    $display("test exceptions done");
    tx(0, 1, 0, 0, 0, 0);
    u_src.idle();
    soft_reset <= 1;
    @(posedge ref_clk);
    soft_reset <= 0;
    pos = '{default: 0};
    inp = '{default: 0};
    last = -1;
    @(posedge ref_clk);
    tx(0, 1, 1, 0, 0, 0);
    drain();
    $display("test soft reset done");
    // a very low throttle could starve a beat past the bounded wait
    throttle <= 9'(64 + $urandom % 192);
    @(posedge ref_clk);
    for (i = 0; i < 40; i++) tx(2 + i % 2, 1, 1, 1, 0, 0);
    drain();
    $display("test full queue done");
    conclude();
  end
endmodule
